// >>> core/rsb_pkg.sv
// constants and types of the receive signaling buffer
`default_nettype none

package rsb_pkg;

   // bus geometry
   localparam int RSB_DW = 32;
   localparam int RSB_AW = 10;
   localparam int RSB_BW = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] RSB_IDX_CFG = 8'hd2;
   localparam logic [7:0] RSB_IDX_STAT = 8'hd3;
   localparam logic [7:0] RSB_IDX_CTRL = 8'hd4;
   localparam logic [7:0] RSB_IDX_DATA = 8'hd5;
   localparam logic [7:0] RSB_IDX_FLAG0 = 8'hd6;
   localparam logic [7:0] RSB_IDX_FLAG1 = 8'hd7;
   localparam logic [7:0] RSB_IDX_FLAG2 = 8'hd8;
   localparam logic [7:0] RSB_IDX_FLAG3 = 8'hd9;
   localparam logic [7:0] RSB_IDX_ISTAT = 8'he0;
   localparam logic [7:0] RSB_IDX_IMASK = 8'he1;

   // configuration fields
   localparam int RSB_CFG_FREEZE = 3;
   localparam int RSB_CFG_DEB = 2;
   localparam int RSB_CFG_SIGNALING_CHANGE_IRQ_ENABLE = 1;
   localparam logic [7:0] RSB_CFG_WMASK = 8'h0e;

   // access control fields
   localparam int RSB_CTRL_DIR = 7;
   localparam int RSB_ADDR_W = 7;
   localparam logic [6:0] RSB_TS_LO_FIRST = 7'h01;
   localparam logic [6:0] RSB_TS_LO_LAST = 7'h0f;
   localparam logic [6:0] RSB_TS_HI_FIRST = 7'h11;
   localparam logic [6:0] RSB_TS_HI_LAST = 7'h1f;

   // per-timeslot entry
   localparam int RSB_ENT_EXT = 4;
   localparam logic RSB_EXT_RESET = 1'b1;
   localparam int RSB_NUM_TS = 32;
   localparam int RSB_TS_W = 5;
   localparam int RSB_SIG_W = 4;

   // change flags: flag k (1..30) sits at vector bit k-1
   localparam int RSB_NUM_FLAGS = 30;
   localparam int RSB_FLAG_SKIP = 15;
   localparam int RSB_FLAG3_W = 6;
   localparam int RSB_FLAG1_LSB = 8;
   localparam int RSB_FLAG2_LSB = 16;
   localparam int RSB_FLAG3_LSB = 24;

   // byte lane bits below the register index
   localparam int RSB_ADR_LSB = 2;

   // interrupt status bits
   localparam int RSB_IRQ_CHG = 0;
   localparam int RSB_IRQ_DONE = 1;
   localparam int RSB_IRQ_W = 2;

   typedef enum logic {RSB_ACC_IDLE, RSB_ACC_RUN} rsb_acc_state_t;

endpackage : rsb_pkg

`default_nettype wire

// >>> core/rsb_top.sv
// receive signaling buffer with indirect access and change flags
`default_nettype none

module rsb_top
   import rsb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [RSB_AW-1:0] wb_adr_i,
   input wire logic [RSB_DW-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [RSB_DW-1:0] wb_dat_o,
   output logic wb_ack_o,
   // received signaling codewords
   input wire logic sig_valid,
   input wire logic [RSB_TS_W-1:0] sig_ts,
   input wire logic [RSB_SIG_W-1:0] sig_abcd,
   input wire logic mf_sync,
   // interrupt
   output logic irq
);

   // state
   logic ack_reg;
   logic [RSB_DW-1:0] rdat_reg;
   logic irq_reg;
   logic [RSB_BW-1:0] cfg_reg;
   logic [RSB_BW-1:0] ctrl_reg;
   logic [RSB_BW-1:0] data_reg;
   logic [RSB_BW-1:0] data_next;
   rsb_acc_state_t acc_reg;
   rsb_acc_state_t acc_next;
   logic [RSB_NUM_TS-1:0] ext_reg;
   logic [RSB_SIG_W-1:0] sig_mem [RSB_NUM_TS];
   logic [RSB_SIG_W-1:0] prev_mem [RSB_NUM_TS];
   logic [RSB_NUM_FLAGS-1:0] flag_reg;
   logic [RSB_NUM_FLAGS-1:0] flag_set;
   logic [RSB_IRQ_W-1:0] istat_reg;
   logic [RSB_IRQ_W-1:0] istat_clr;
   logic [RSB_IRQ_W-1:0] imask_reg;

   // bus decode
   wire [RSB_BW-1:0] idx = wb_adr_i[RSB_AW-1:RSB_ADR_LSB];
   wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
   wire wr = req & wb_we_i & wb_sel_i[0];
   wire rd = req & ~wb_we_i;
   wire [RSB_BW-1:0] wbyte = wb_dat_i[RSB_BW-1:0];
   wire hit_cfg = idx == RSB_IDX_CFG;
   wire hit_stat = idx == RSB_IDX_STAT;
   wire hit_ctrl = idx == RSB_IDX_CTRL;
   wire hit_data = idx == RSB_IDX_DATA;
   wire hit_f0 = idx == RSB_IDX_FLAG0;
   wire hit_f1 = idx == RSB_IDX_FLAG1;
   wire hit_f2 = idx == RSB_IDX_FLAG2;
   wire hit_f3 = idx == RSB_IDX_FLAG3;
   wire hit_istat = idx == RSB_IDX_ISTAT;
   wire hit_imask = idx == RSB_IDX_IMASK;
   wire idle = acc_reg == RSB_ACC_IDLE;

   // config bits
   wire cfg_freeze = cfg_reg[RSB_CFG_FREEZE];
   wire cfg_deb = cfg_reg[RSB_CFG_DEB];
   wire cfg_signaling_change_irq_enable = cfg_reg[RSB_CFG_SIGNALING_CHANGE_IRQ_ENABLE];

   // control and data writes are dropped while busy
   wire start_op = wr & hit_ctrl & idle;
   wire data_wr = wr & hit_data & idle;

   // indirect target
   wire [RSB_ADDR_W-1:0] ind_addr = ctrl_reg[RSB_ADDR_W-1:0];
   wire [RSB_TS_W-1:0] ind_ts = ind_addr[RSB_TS_W-1:0];
   // only the two timeslot ranges decode
   wire ind_ok = ((ind_addr >= RSB_TS_LO_FIRST) && (ind_addr <= RSB_TS_LO_LAST))
      || ((ind_addr >= RSB_TS_HI_FIRST) && (ind_addr <= RSB_TS_HI_LAST));
   wire ind_read = ctrl_reg[RSB_CTRL_DIR];
   wire run = acc_reg == RSB_ACC_RUN;
   // entry layout: extract enable over signaling bits
   wire [RSB_BW-1:0] ind_entry = ind_ok ?
      RSB_BW'({ext_reg[ind_ts], sig_mem[ind_ts]}) : '0;
   // direction bit selects read or write
   wire ind_wr_go = run & ~ind_read & ind_ok;
   wire ind_rd_go = run & ind_read;

   // receive side: timeslots 0 and 16 carry no channel signaling
   wire [RSB_ADDR_W-1:0] rx_addr = RSB_ADDR_W'(sig_ts);
   wire rx_ts_ok = ((rx_addr >= RSB_TS_LO_FIRST) && (rx_addr <= RSB_TS_LO_LAST))
      || ((rx_addr >= RSB_TS_HI_FIRST) && (rx_addr <= RSB_TS_HI_LAST));
   wire rx_seen = sig_valid & rx_ts_ok;
   // update only with extraction on and multiframe in sync
   // freeze holds the last valid value
   wire rx_take = rx_seen & mf_sync & ext_reg[sig_ts] & ~cfg_freeze;
   // two matching codewords in a row needed
   wire deb_ok = ~cfg_deb | (sig_abcd == prev_mem[sig_ts]);
   wire rx_upd = rx_take & deb_ok & (sig_abcd != sig_mem[sig_ts]);
   wire [RSB_NUM_TS-1:0] chg_ts = rx_upd ? (RSB_NUM_TS'(1) << sig_ts) : '0;

   // flag clears, one write-one-to-clear byte per register
   wire [RSB_BW-1:0] clr0 = (wr & hit_f0) ? wbyte : '0;
   wire [RSB_BW-1:0] clr1 = (wr & hit_f1) ? wbyte : '0;
   wire [RSB_BW-1:0] clr2 = (wr & hit_f2) ? wbyte : '0;
   wire [RSB_FLAG3_W-1:0] clr3 = (wr & hit_f3) ? wbyte[RSB_FLAG3_W-1:0] : '0;
   wire [RSB_NUM_FLAGS-1:0] flag_clr = {clr3, clr2, clr1, clr0};

   // flag to timeslot: skip timeslot 16
   genvar gi;
   generate
      for (gi = 0; gi < RSB_NUM_FLAGS; gi++) begin : g_flag
         localparam int TS = (gi < RSB_FLAG_SKIP) ? gi + 1 : gi + 2;
         assign flag_set[gi] = chg_ts[TS];
      end
   endgenerate

   // write-one clears, set wins over clear
   rsb_sticky #(
      .W(RSB_NUM_FLAGS)
   ) u_flags (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .set(flag_set),
      .clr(flag_clr),
      .q(flag_reg)
   );

   // flag register images
   // bits 7..0 are timeslots 8..1
   wire [RSB_BW-1:0] flag0_rd = flag_reg[RSB_FLAG1_LSB-1:0];
   // bits 6..0 are timeslots 15..9, bit 7 is timeslot 17
   wire [RSB_BW-1:0] flag1_rd = flag_reg[RSB_FLAG2_LSB-1:RSB_FLAG1_LSB];
   wire [RSB_BW-1:0] flag2_rd = flag_reg[RSB_FLAG3_LSB-1:RSB_FLAG2_LSB];
   // timeslots 31..26, top two bits read zero
   wire [RSB_BW-1:0] flag3_rd = RSB_BW'(flag_reg[RSB_NUM_FLAGS-1:RSB_FLAG3_LSB]);

   // busy in bit 0 of access status
   wire [RSB_BW-1:0] stat_rd = RSB_BW'(run);

   // read mux; unmapped indices answer zero
   wire [RSB_BW-1:0] rd_byte =
      hit_cfg ? cfg_reg :
      hit_stat ? stat_rd :
      hit_ctrl ? ctrl_reg :
      hit_data ? data_reg :
      hit_f0 ? flag0_rd :
      hit_f1 ? flag1_rd :
      hit_f2 ? flag2_rd :
      hit_f3 ? flag3_rd :
      hit_istat ? RSB_BW'(istat_reg) :
      hit_imask ? RSB_BW'(imask_reg) : '0;

   // sticky events, cleared by a read of the status
   wire [RSB_IRQ_W-1:0] ev;
   assign ev[RSB_IRQ_CHG] = |chg_ts;
   assign ev[RSB_IRQ_DONE] = run;
   wire istat_rd = rd & hit_istat;
   assign istat_clr = istat_rd ? {RSB_IRQ_W{1'b1}} : '0;

   // an event in the clearing read cycle survives
   rsb_sticky #(
      .W(RSB_IRQ_W)
   ) u_events (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .set(ev),
      .clr(istat_clr),
      .q(istat_reg)
   );

   // change flags reach irq only with the enable set
   wire irq_next = (cfg_signaling_change_irq_enable & (|flag_reg)) | (|(istat_reg & imask_reg));

   // one run cycle commits the access then busy falls
   always_comb begin
      acc_next = acc_reg;
      case (acc_reg)
         RSB_ACC_IDLE: begin
            if (start_op) begin
               acc_next = RSB_ACC_RUN;
            end
         end
         RSB_ACC_RUN: begin
            acc_next = RSB_ACC_IDLE;
         end
         default: begin
            acc_next = RSB_ACC_IDLE;
         end
      endcase
   end

   // read result lands in the data register
   // a host data write is only taken while idle
   always_comb begin
      data_next = data_reg;
      if (ind_rd_go) begin
         data_next = ind_entry;
      end else if (data_wr) begin
         data_next = wbyte;
      end
   end

   // bus answer: one-cycle ack, dropped the cycle after
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ack_reg <= 1'b0;
         rdat_reg <= '0;
      end else begin
         ack_reg <= req;
         rdat_reg <= rd ? RSB_DW'(rd_byte) : '0;
      end
   end

   // software registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cfg_reg <= '0;
         ctrl_reg <= '0;
         imask_reg <= '0;
      end else begin
         if (wr & hit_cfg) begin
            cfg_reg <= wbyte & RSB_CFG_WMASK;
         end
         if (start_op) begin
            ctrl_reg <= wbyte;
         end
         if (wr & hit_imask) begin
            imask_reg <= wbyte[RSB_IRQ_W-1:0];
         end
      end
   end

   // access engine and data register
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         acc_reg <= RSB_ACC_IDLE;
         data_reg <= '0;
      end else begin
         acc_reg <= acc_next;
         data_reg <= data_next;
      end
   end

   // extract enables, written only through the indirect port
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_reg <= {RSB_NUM_TS{RSB_EXT_RESET}};
      end else if (ind_wr_go) begin
         // only bit 4 of an entry is writable
         ext_reg[ind_ts] <= data_reg[RSB_ENT_EXT];
      end
   end

   // stored signaling and last received codeword per timeslot
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < RSB_NUM_TS; i++) begin
            sig_mem[i] <= '0;
            prev_mem[i] <= '0;
         end
      end else begin
         // debounce compares against every codeword seen, frozen or not
         if (rx_seen) begin
            prev_mem[sig_ts] <= sig_abcd;
         end
         if (rx_upd) begin
            sig_mem[sig_ts] <= sig_abcd;
         end
      end
   end

   // interrupt
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   // outputs straight from flops
   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;
   assign irq = irq_reg;

endmodule : rsb_top

// sticky bits: set wins over a clear in the same cycle
module rsb_sticky
   import rsb_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // events and clears
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   // held bits
   output logic [W-1:0] q
);

   logic [W-1:0] q_reg;
   logic [W-1:0] q_next;

   assign q_next = set | (q_reg & ~clr);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;

endmodule : rsb_sticky

`default_nettype wire

// >>> dv/rsb_properties.sv
// port assertions of the receive signaling buffer
`default_nettype none
module rsb_checker
   import rsb_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // bus and receive side
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [RSB_DW-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic sig_valid,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic req = wb_cyc_i & wb_stb_i;
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows_req: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(req))
      else $error("ack without request");
   a_ack_idle_quiet: assert property (!req |=> !wb_ack_o)
      else $error("ack while idle");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("read data outside ack");
   a_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[RSB_DW-1:8] == '0)
      else $error("upper read data not zero");
   a_irq_rise_cause: assert property ($rose(irq) |->
      $past(sig_valid, 2) || $past(wb_we_i & req) || $past(wb_we_i & req, 2)
      || $past(wb_we_i & req, 3))
      else $error("interrupt rose without cause");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(req) || $past(req, 2))
      else $error("interrupt fell without access");
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_irq: cover property ($rose(irq));
   c_codeword: cover property (sig_valid);
endmodule : rsb_checker
bind rsb_top rsb_checker u_chk (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .sig_valid(sig_valid), .irq(irq));
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench of the receive signaling buffer
`default_nettype none
module tb
   import rsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rstn, cyc, stb, we, sv, mf, ack, irq;
   logic [RSB_AW-1:0] adr;
   logic [RSB_DW-1:0] wdat, dato;
   logic [3:0] sel;
   logic [RSB_TS_W-1:0] ts;
   logic [RSB_SIG_W-1:0] abcd;
   int mismatches, n_tests;
   rsb_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dato),
      .wb_ack_o(ack), .sig_valid(sv), .sig_ts(ts), .sig_abcd(abcd), .mf_sync(mf), .irq(irq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
      output logic [7:0] q);
      int i;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      wdat <= {24'h0, d};
      i = 0;
      do begin
         @(posedge sys_clk);
         i++;
      end while (ack !== 1'b1 && i < 50);
      chk({7'h0, ack}, 8'h01);
      q = dato[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, idx, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, idx, 8'h00, q);
      chk(q, exp);
   endtask : rd
   task automatic ird(input logic [6:0] a, input logic [7:0] exp);
      // busy has dropped before the next request is sampled
      wr(RSB_IDX_CTRL, {1'b1, a});
      rd(RSB_IDX_DATA, exp);
   endtask : ird
   task automatic rx(input logic [4:0] t, input logic [3:0] c);
      @(posedge sys_clk);
      sv <= 1'b1;
      ts <= t;
      abcd <= c;
      @(posedge sys_clk);
      sv <= 1'b0;
   endtask : rx
   task automatic irq_is(input logic v);
      repeat (2) @(posedge sys_clk);
      chk({7'h0, irq}, {7'h0, v});
   endtask : irq_is
   task automatic t_reset();
      for (int i = 'hd2; i <= 'hd9; i++) rd(i[7:0], 8'h00);
      rd(8'he5, 8'h00);
      sel <= 4'he;
      wr(RSB_IDX_CFG, 8'h0e);
      sel <= 4'hf;
      rd(RSB_IDX_CFG, 8'h00);
   endtask : t_reset
   task automatic t_indirect();
      ird(7'h05, 8'h10);
      wr(RSB_IDX_DATA, 8'h00);
      wr(RSB_IDX_CTRL, 8'h05);
      rx(5'd5, 4'h3);
      ird(7'h05, 8'h00);
      wr(RSB_IDX_DATA, 8'hff);
      wr(RSB_IDX_CTRL, 8'h05);
      ird(7'h05, 8'h10);
      ird(7'h10, 8'h00);
      rd(RSB_IDX_STAT, 8'h00);
   endtask : t_indirect
   task automatic t_map();
      logic [7:0] tab [10][3] = '{'{1, 'hd6, 'h01}, '{8, 'hd6, 'h80}, '{9, 'hd7, 'h01},
         '{15, 'hd7, 'h40}, '{16, 'hd7, 'h00}, '{17, 'hd7, 'h80}, '{18, 'hd8, 'h01},
         '{25, 'hd8, 'h80}, '{26, 'hd9, 'h01}, '{31, 'hd9, 'h20}};
      foreach (tab[i]) begin
         rx(tab[i][0][4:0], 4'ha);
         rd(tab[i][1], tab[i][2]);
         wr(tab[i][1], tab[i][2]);
         rd(tab[i][1], 8'h00);
         ird(tab[i][0][6:0], (tab[i][2] != 0) ? 8'h1a : 8'h00);
      end
   endtask : t_map
   task automatic t_w1c();
      rx(5'd3, 4'h6);
      wr(RSB_IDX_FLAG0, 8'h00);
      rd(RSB_IDX_FLAG0, 8'h04);
      wr(RSB_IDX_FLAG0, 8'h04);
      rx(5'd3, 4'h6);
      rd(RSB_IDX_FLAG0, 8'h00);
   endtask : t_w1c
   task automatic t_irq();
      rd(RSB_IDX_ISTAT, 8'h03);
      wr(RSB_IDX_CFG, 8'h02);
      rx(5'd2, 4'h5);
      irq_is(1'b1);
      wr(RSB_IDX_FLAG0, 8'h02);
      irq_is(1'b0);
      wr(RSB_IDX_CFG, 8'h00);
      wr(RSB_IDX_IMASK, 8'h01);
      rd(RSB_IDX_ISTAT, 8'h01);
      rx(5'd2, 4'h9);
      irq_is(1'b1);
      rd(RSB_IDX_FLAG0, 8'h02);
      wr(RSB_IDX_FLAG0, 8'h02);
      irq_is(1'b1);
      rd(RSB_IDX_ISTAT, 8'h01);
      irq_is(1'b0);
      wr(RSB_IDX_IMASK, 8'h02);
      ird(7'h01, 8'h1a);
      irq_is(1'b1);
      rd(RSB_IDX_ISTAT, 8'h02);
      irq_is(1'b0);
      wr(RSB_IDX_IMASK, 8'h00);
   endtask : t_irq
   task automatic t_hold();
      wr(RSB_IDX_CFG, 8'h04);
      rx(5'd4, 4'h5);
      ird(7'h04, 8'h10);
      rx(5'd4, 4'h5);
      ird(7'h04, 8'h15);
      wr(RSB_IDX_CFG, 8'h08);
      rx(5'd6, 4'h7);
      ird(7'h06, 8'h10);
      wr(RSB_IDX_CFG, 8'h00);
      mf <= 1'b0;
      rx(5'd6, 4'h7);
      ird(7'h06, 8'h10);
      mf <= 1'b1;
      rd(RSB_IDX_FLAG0, 8'h08);
   endtask : t_hold
   task automatic test_done();
      $display("mismatches %0d of %0d comparisons", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      test_done();
   end
   initial begin
      {rstn, cyc, stb, we, sv, adr, wdat, ts, abcd} = '0;
      {mf, sel} = 5'h1f;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      t_reset();
      t_indirect();
      t_map();
      t_w1c();
      t_irq();
      t_hold();
      test_done();
   end
endmodule : tb
`default_nettype wire
